// File: verilog/tpg_pkg.sv
// Purpose: Shared constants for the test pattern and gain select block
// Assumes: 8-bit registers, one per aligned 32-bit word at four times the index
// Notes: Pattern codes, gain table and sine table live here
package tpg_pkg;
  localparam int SAMP_W = 14;
  localparam int NUM_CH = 4;
  localparam int WORD_W = 56;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;

  localparam logic [IDX_W-1:0] IDX_PAT_SEL_CD = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_GAIN_AB = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_GAIN_CD = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_CW_HIGH = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_CW_LOW = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h10;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h11;

  localparam int HI_NIB_LSB = 4;
  localparam int LO_NIB_LSB = 0;
  localparam int CW_LOW_LSB = 2;
  localparam int CTRL_PAT_EN_BIT = 0;
  localparam int CTRL_ALIGN_BIT = 1;
  localparam int CTRL_GAIN_EN_LSB = 4;
  localparam logic [7:0] REG_RST = 8'h00;

  localparam logic [3:0] PAT_NORMAL = 4'h0;
  localparam logic [3:0] PAT_ZEROS = 4'h1;
  localparam logic [3:0] PAT_ONES = 4'h2;
  localparam logic [3:0] PAT_TOGGLE = 4'h3;
  localparam logic [3:0] PAT_RAMP = 4'h4;
  localparam logic [3:0] PAT_CUSTOM = 4'h5;
  localparam logic [3:0] PAT_DESKEW = 4'h6;
  localparam logic [3:0] PAT_PRBS = 4'h8;
  localparam logic [3:0] PAT_SINE = 4'h9;

  localparam logic [13:0] TOGGLE_EVEN = 14'h2aaa;
  localparam logic [13:0] TOGGLE_ODD = 14'h1555;
  localparam logic [13:0] DESKEW_WORD = 14'h3aaa;
  localparam logic [13:0] RAMP_START = 14'h0000;
  localparam logic [14:0] PRBS_SEED = 15'h7fff;
  localparam logic [13:0] SINE_TABLE [8] = '{14'h0000, 14'h095f, 14'h2000, 14'h36a0,
                                             14'h3fff, 14'h36a0, 14'h2000, 14'h095f};

  localparam int GAIN_FRAC = 10;
  localparam logic [3:0] GAIN_CODE_MAX = 4'hc;
  localparam logic [11:0] GAIN_Q10 [13] = '{12'h400, 12'h43d, 12'h47d, 12'h4c1, 12'h509,
                                           12'h556, 12'h5a6, 12'h5fc, 12'h657, 12'h6b7,
                                           12'h71d, 12'h789, 12'h7fb};
  localparam logic signed [16:0] SAT_POS = 17'sh01fff;
  localparam logic signed [16:0] SAT_NEG = -17'sh02000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tpg_pkg

// File: verilog/tpg_fifo_if.sv
// Purpose: Carries words between the pattern logic and the output FIFO
// Assumes: One clock shared by both ends
// Notes: level counts words held in storage
`timescale 1ns/1ps
interface tpg_fifo_if #(parameter int WIDTH = 56, parameter int DEPTH = 16);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic [$clog2(DEPTH):0] level;
  modport prod (output in_valid, input in_ready, output in_data,
                input out_valid, output out_ready, input out_data, input level);
  modport fifo (input in_valid, output in_ready, input in_data,
                output out_valid, input out_ready, output out_data, output level);
endinterface : tpg_fifo_if

// File: verilog/tpg_fifo.sv
// Purpose: Word FIFO with a registered output stage
// Assumes: Synchronous active-low reset
// Notes: in_ready and out_valid are flip-flops so the top drives them straight out
`timescale 1ns/1ps
module tpg_fifo #(
  parameter int WIDTH = 56,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  tpg_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic in_ready_r;
  logic out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  logic push;
  logic pop;

  assign push = f.in_valid && in_ready_r;
  assign pop = (cnt_r != '0) && (!out_valid_r || f.out_ready);
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign f.in_ready = in_ready_r;
  assign f.out_valid = out_valid_r;
  assign f.out_data = out_data_r;
  assign f.level = cnt_r;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_r] <= f.in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      cnt_r <= cnt_nxt;
      // Registered full flag: stalls the source before storage overflows
      in_ready_r <= cnt_nxt < (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (pop) begin
      out_valid_r <= 1'b1;
      out_data_r <= mem[rd_ptr_r];
    end else if (f.out_ready) begin
      out_valid_r <= 1'b0;
    end
  end
endmodule : tpg_fifo

// File: verilog/tpg_top.sv
// Purpose: Test pattern select for channels C and D, digital gain for all four channels
// Assumes: Samples arrive on aclk with a valid/ready handshake, one per sample cycle
// Notes: Registers reached over AXI4-Lite; output words pass a 16-word FIFO
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tpg_top
  import tpg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic [WORD_W-1:0] samp_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WORD_W-1:0] out_data
);
  logic [7:0] pattern_select_c_d_r;
  logic [7:0] digital_gain_a_b_r;
  logic [7:0] digital_gain_c_d_r;
  logic [7:0] custom_word_high_r;
  logic [7:0] custom_word_low_r;
  logic [7:0] ctrl_r;
  logic aw_have_r;
  logic w_have_r;
  logic [IDX_W-1:0] aw_idx_r;
  logic [7:0] w_byte_r;
  logic w_lane0_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wr_do;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [IDX_W-1:0] ar_idx;
  logic samp_fire;
  logic pat_en;
  logic align;
  logic [3:0] gain_en;
  logic [13:0] custom_word;
  logic [7:0] sel_prev_r;
  logic en_prev_r;
  logic [1:0] chg;
  logic [1:0][13:0] pat_word;
  logic [1:0][3:0] pat_code;
  logic [3:0][13:0] samp_ch;
  logic [3:0][13:0] gained;
  logic [3:0][3:0] gain_code;

  tpg_fifo_if #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) ff ();

  tpg_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .f(ff.fifo)
  );

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign samp_ready = ff.in_ready;
  assign out_valid = ff.out_valid;
  assign out_data = ff.out_data;
  assign ff.out_ready = out_ready;

  // Write channel: address and data taken in either order, one write at a time
  assign wr_do = aw_have_r && w_have_r && !bvalid_r;
  assign wr_hit = (aw_idx_r >= IDX_PAT_SEL_CD) && (aw_idx_r <= IDX_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      awready_r <= 1'b0;
      aw_idx_r <= '0;
    end else if (s_axi_awvalid && awready_r) begin
      aw_have_r <= 1'b1;
      awready_r <= 1'b0;
      aw_idx_r <= s_axi_awaddr[ADDR_W-1:2];
    end else if (wr_do) begin
      aw_have_r <= 1'b0;
    end else if (!aw_have_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wready_r <= 1'b0;
      w_byte_r <= '0;
      w_lane0_r <= 1'b0;
    end else if (s_axi_wvalid && wready_r) begin
      w_have_r <= 1'b1;
      wready_r <= 1'b0;
      w_byte_r <= s_axi_wdata[7:0];
      w_lane0_r <= s_axi_wstrb[0];
    end else if (wr_do) begin
      w_have_r <= 1'b0;
    end else if (!w_have_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Writes land at once; the sample path reads them at its next sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pattern_select_c_d_r <= REG_RST;
      digital_gain_a_b_r <= REG_RST;
      digital_gain_c_d_r <= REG_RST;
      custom_word_high_r <= REG_RST;
      custom_word_low_r <= REG_RST;
      ctrl_r <= REG_RST;
    end else if (wr_do && w_lane0_r) begin
      unique case (aw_idx_r)
        IDX_PAT_SEL_CD: pattern_select_c_d_r <= w_byte_r;
        IDX_GAIN_AB: digital_gain_a_b_r <= w_byte_r;
        IDX_GAIN_CD: digital_gain_c_d_r <= w_byte_r;
        IDX_CW_HIGH: custom_word_high_r <= w_byte_r;
        IDX_CW_LOW: custom_word_low_r <= {w_byte_r[7:2], 2'b00};
        IDX_CTRL: ctrl_r <= w_byte_r;
        default: ;
      endcase
    end
  end

  // Read channel: answer one cycle after the address is taken
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rd_hit = 1'b1;
    unique case (ar_idx)
      IDX_PAT_SEL_CD: rd_byte = pattern_select_c_d_r;
      IDX_GAIN_AB: rd_byte = digital_gain_a_b_r;
      IDX_GAIN_CD: rd_byte = digital_gain_c_d_r;
      IDX_CW_HIGH: rd_byte = custom_word_high_r;
      IDX_CW_LOW: rd_byte = custom_word_low_r;
      IDX_CTRL: rd_byte = ctrl_r;
      IDX_STATUS: rd_byte = {3'h0, ff.level};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= {24'h000000, rd_byte};
    end else if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end else begin
      arready_r <= 1'b1;
    end
  end

  // Sample path
  assign samp_fire = samp_valid && ff.in_ready;
  assign pat_en = ctrl_r[CTRL_PAT_EN_BIT];
  assign align = ctrl_r[CTRL_ALIGN_BIT];
  assign gain_en = ctrl_r[CTRL_GAIN_EN_LSB +: 4];
  assign custom_word = {custom_word_high_r, custom_word_low_r[7:CW_LOW_LSB]};
  assign pat_code[0] = pattern_select_c_d_r[HI_NIB_LSB +: 4];
  assign pat_code[1] = pattern_select_c_d_r[LO_NIB_LSB +: 4];
  assign gain_code[3] = digital_gain_a_b_r[HI_NIB_LSB +: 4];
  assign gain_code[2] = digital_gain_a_b_r[LO_NIB_LSB +: 4];
  assign gain_code[1] = digital_gain_c_d_r[HI_NIB_LSB +: 4];
  assign gain_code[0] = digital_gain_c_d_r[LO_NIB_LSB +: 4];

  // Reserved codes fall back to unity so a bad write cannot overdrive the output
  function automatic logic [13:0] apply_gain(input logic [13:0] s, input logic [3:0] code);
    logic [11:0] fac;
    logic signed [26:0] prod;
    logic signed [16:0] q;
    fac = (code > GAIN_CODE_MAX) ? GAIN_Q10[0] : GAIN_Q10[code];
    prod = $signed(s) * $signed({1'b0, fac});
    q = prod[GAIN_FRAC +: 17];
    if (q > SAT_POS) begin
      apply_gain = SAT_POS[13:0];
    end else if (q < SAT_NEG) begin
      apply_gain = SAT_NEG[13:0];
    end else begin
      apply_gain = q[13:0];
    end
  endfunction : apply_gain

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_gain
      assign samp_ch[gi] = samp_data[gi*SAMP_W +: SAMP_W];
      assign gained[gi] = gain_en[gi] ? apply_gain(samp_ch[gi], gain_code[gi]) : samp_ch[gi];
    end
  endgenerate

  // A generator restarts when its selection changes; aligned, both restart together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_prev_r <= REG_RST;
      en_prev_r <= 1'b0;
    end else if (samp_fire) begin
      sel_prev_r <= pattern_select_c_d_r;
      en_prev_r <= pat_en;
    end
  end

  assign chg[0] = (pat_code[0] != sel_prev_r[HI_NIB_LSB +: 4]) || (pat_en != en_prev_r);
  assign chg[1] = (pat_code[1] != sel_prev_r[LO_NIB_LSB +: 4]) || (pat_en != en_prev_r);

  generate
    for (gi = 0; gi < 2; gi++) begin : g_pat
      logic [13:0] ramp_r;
      logic tog_r;
      logic [2:0] sine_r;
      logic [14:0] prbs_r;
      logic restart;
      logic [13:0] ramp_cur;
      logic tog_cur;
      logic [2:0] sine_cur;
      logic [14:0] prbs_cur;
      logic [13:0] word;

      assign restart = align ? (chg != 2'b00) : chg[gi];
      assign ramp_cur = restart ? RAMP_START : ramp_r;
      assign tog_cur = restart ? 1'b0 : tog_r;
      assign sine_cur = restart ? 3'h0 : sine_r;
      assign prbs_cur = restart ? PRBS_SEED : prbs_r;

      // Ramp wraps from full scale to zero by plain overflow
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ramp_r <= RAMP_START;
        end else if (samp_fire) begin
          ramp_r <= ramp_cur + 14'h0001;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tog_r <= 1'b0;
        end else if (samp_fire) begin
          tog_r <= !tog_cur;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sine_r <= 3'h0;
        end else if (samp_fire) begin
          sine_r <= sine_cur + 3'h1;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          prbs_r <= PRBS_SEED;
        end else if (samp_fire) begin
          prbs_r <= {prbs_cur[13:0], prbs_cur[14] ^ prbs_cur[13]};
        end
      end

      always_comb begin
        unique case (pat_code[gi])
          PAT_ZEROS: word = 14'h0000;
          PAT_ONES: word = 14'h3fff;
          PAT_TOGGLE: word = tog_cur ? TOGGLE_ODD : TOGGLE_EVEN;
          PAT_RAMP: word = ramp_cur;
          PAT_CUSTOM: word = custom_word;
          PAT_DESKEW: word = DESKEW_WORD;
          PAT_PRBS: word = prbs_cur[13:0];
          PAT_SINE: word = SINE_TABLE[sine_cur];
          default: word = gained[1-gi];
        endcase
      end

      assign pat_word[gi] = pat_en ? word : gained[1-gi];
    end
  endgenerate

  // Word order on the FIFO: A in the top slice, D in the bottom
  assign ff.in_valid = samp_valid;
  assign ff.in_data = {gained[3], gained[2], pat_word[0], pat_word[1]};
endmodule : tpg_top

// File: tb/tpg_checker.sv
// Purpose: Port checks on the register bus and output stream
// Assumes: One clock, synchronous active-low reset
// Notes: Register contents are not visible here, only handshakes and port data
`timescale 1ns/1ps
module tpg_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [55:0] out_data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_answer;
    s_axi_rvalid && !s_axi_arready;
  endsequence
  a_rd_answer: assert property (s_ar_taken |=> s_rd_answer)
    else $error("read not answered next cycle");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data)) else $error("output word dropped");
endmodule : tpg_checker

// File: tb/tpg_host.sv
// Purpose: Host model issuing register cycles
// Assumes: One write and one read at a time
// Notes: Released write data and read address are inverted so stale values never look valid
`timescale 1ns/1ps
module tpg_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = 8'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    if (a == 8'h3c) begin
      d[1:0] = 2'h0;
    end
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    s_axi_wdata <= ~{24'h0, d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    s_axi_araddr <= ~a;
  endtask : rd
endmodule : tpg_host

// File: tb/tb_test_pattern_and_gain_select.sv
// Purpose: Register and pattern tests for the pattern and gain block
// Assumes: Host model drives the bus, this bench drives the stream
// Notes: Pattern lanes ignore input data, so one word is repeated
`timescale 1ns/1ps
module tb_test_pattern_and_gain_select
  import tpg_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic samp_valid = 1'b0;
  logic out_ready = 1'b1;
  logic samp_ready, out_valid;
  logic [WORD_W-1:0] samp_data = '0;
  logic [WORD_W-1:0] out_data, w;
  logic [WORD_W-1:0] q[$];
  logic [14:0] lf;
  logic [13:0] sn[8] = '{14'h0, 14'h95f, 14'h2000, 14'h36a0, 14'h3fff, 14'h36a0, 14'h2000,
                        14'h95f};
  logic [3:0] fc[4] = '{PAT_ZEROS, PAT_ONES, PAT_DESKEW, PAT_CUSTOM};
  logic [13:0] fe[4] = '{14'h0, 14'h3fff, 14'h3aaa, 14'h2af3};
  int n_fail = 0;
  int num_checks = 0;
  always #12.5 aclk = ~aclk;
  tpg_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .samp_valid, .samp_ready, .samp_data, .out_valid, .out_ready, .out_data);
  tpg_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  always @(posedge aclk) begin
    if (out_valid && out_ready) q.push_back(out_data);
  end
  task automatic chk(input logic [WORD_W-1:0] s, input logic [WORD_W-1:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    host.wr(a, v, r);
    chk(r, er);
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    host.rd(a, rv, r);
    chk(rv, {24'h0, e});
    chk(r, er);
  endtask : rchk
  // Holds valid across back-to-back words; one edge of gap on entry
  task automatic send(input logic [WORD_W-1:0] v, input int n);
    @(posedge aclk);
    samp_data <= v;
    samp_valid <= 1'b1;
    repeat (n) begin
      do @(posedge aclk); while (!samp_ready);
    end
    samp_valid <= 1'b0;
    samp_data <= ~v;
  endtask : send
  task automatic take(output logic [WORD_W-1:0] v);
    for (int i = 0; i < 100 && q.size() == 0; i++) @(posedge aclk);
    v = (q.size() > 0) ? q.pop_front() : 'x;
  endtask : take
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h2c, 8'h00, RESP_OKAY);
    wreg(8'h3c, 8'hcf, RESP_OKAY);
    rchk(8'h3c, 8'hcc, RESP_OKAY);
    wreg(8'h38, 8'hab, RESP_OKAY);
    rchk(8'h38, 8'hab, RESP_OKAY);
    wreg(8'h80, 8'h55, RESP_SLVERR);
    rchk(8'h80, 8'h00, RESP_SLVERR);
    wreg(8'h40, 8'h01, RESP_OKAY);
    foreach (fc[k]) begin
      wreg(8'h2c, {fc[k], fc[k]}, RESP_OKAY);
      send(56'h0123456789abcd, 1);
      take(w);
      chk(w[27:14], fe[k]);
      chk(w[13:0], fe[k]);
    end
    // Long enough to see the ramp wrap at full scale
    wreg(8'h2c, {PAT_RAMP, PAT_SINE}, RESP_OKAY);
    send('0, 16386);
    for (int k = 0; k < 16386; k++) begin
      take(w);
      chk(w[27:14], k[13:0]);
      chk(w[13:0], sn[k%8]);
    end
    wreg(8'h2c, {PAT_TOGGLE, PAT_PRBS}, RESP_OKAY);
    send('0, 6);
    lf = 15'h7fff;
    for (int k = 0; k < 6; k++) begin
      take(w);
      chk(w[27:14], k[0] ? 14'h1555 : 14'h2aaa);
      chk(w[13:0], lf[13:0]);
      lf = {lf[13:0], lf[14] ^ lf[13]};
    end
    // A change on D alone restarts C only while aligned
    wreg(8'h2c, {PAT_RAMP, PAT_RAMP}, RESP_OKAY);
    send('0, 2);
    for (int k = 0; k < 2; k++) begin
      take(w);
      chk(w[27:0], {k[13:0], k[13:0]});
    end
    wreg(8'h2c, {PAT_RAMP, PAT_SINE}, RESP_OKAY);
    send('0, 1);
    take(w);
    chk(w[27:0], {14'h0002, sn[0]});
    wreg(8'h40, 8'h03, RESP_OKAY);
    wreg(8'h2c, {PAT_RAMP, PAT_TOGGLE}, RESP_OKAY);
    send('0, 1);
    take(w);
    chk(w[27:0], {RAMP_START, TOGGLE_EVEN});
    wreg(8'h30, 8'hc1, RESP_OKAY);
    wreg(8'h34, 8'hcc, RESP_OKAY);
    wreg(8'h40, 8'hf0, RESP_OKAY);
    send({14'h1000, 14'h1234, 14'h1fff, 14'h2000}, 1);
    take(w);
    chk(w, {14'h1fec, 14'h1349, 14'h1fff, 14'h2000});
    wreg(8'h2c, 8'h00, RESP_OKAY);
    wreg(8'h40, 8'h01, RESP_OKAY);
    send({14'h1000, 14'h1234, 14'h1fff, 14'h2000}, 1);
    take(w);
    chk(w, {14'h1000, 14'h1234, 14'h1fff, 14'h2000});
    // Sink stalls: sixteen stored plus one in the output stage
    out_ready <= 1'b0;
    send('0, 17);
    repeat (3) @(posedge aclk);
    chk(samp_ready, 1'b0);
    rchk(8'h44, 8'h10, RESP_OKAY);
    out_ready <= 1'b1;
    for (int k = 0; k < 17; k++) take(w);
    repeat (4) @(posedge aclk);
    chk(q.size(), 0);
    rchk(8'h44, 8'h00, RESP_OKAY);
    end_sim();
  end
endmodule : tb_test_pattern_and_gain_select
bind tpg_top tpg_checker chk_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .out_valid, .out_ready, .out_data);
